/* pkg/gpp_defs.vh */
// Register map and constants for the four-bit general-purpose port
`ifndef GPP_DEFS_VH
`define GPP_DEFS_VH

// Port width
`define GPP_NBITS          4

// APB address width (byte addresses)
`define GPP_AW             16

// Register indices as printed; the byte address is four times the index
`define GPP_IDX_LATCH      16'h0001
`define GPP_IDX_PIN_IN     16'h000e
`define GPP_IDX_DIR        16'h0f1b
`define GPP_IDX_PULLUP     16'h0f28
`define GPP_IDX_FUNC       16'h0f40

// Reset values
`define GPP_RST_LATCH      4'h0
`define GPP_RST_DIR        4'h0
`define GPP_RST_PULLUP     4'h0
`define GPP_RST_FUNC       1'b1

// Field positions
`define GPP_FUNC_RSTPIN    0
`define GPP_BIT_RESET      0
`define GPP_BIT_IRQ_C      1
`define GPP_BIT_IRQ_A      2
`define GPP_BIT_IRQ_B      3

// Direction encoding
`define GPP_DIR_IN         1'b0
`define GPP_DIR_OUT        1'b1

`endif

/* sim/gpp_pins_model.sv */
// Board-side model of the four port pins
`timescale 1ns/10ps
`default_nettype none
module gpp_pins_model (
  input wire logic       pclk,
  input wire logic [3:0] oe, out, pu, en, val,
  output logic     [3:0] pin
);
  logic t = 1'b0;
  // A floating pin toggles so an undriven level never reads as a steady value
  always @(posedge pclk) t <= ~t;
  assign pin = (oe & out) | (~oe & en & val) | (~oe & ~en & (pu | {4{t}}));
endmodule
`default_nettype wire

/* sim/gpp_port_properties.sv */
// Checker for the port's pin and register bus behaviour
`timescale 1ns/10ps
`default_nettype none
`include "gpp_defs.vh"
module gpp_port_properties (
  input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic [3:0]  pstrb, port_pin_in, port_pin_out, port_pin_oe, port_pullup_on,
  input wire logic        ext_irq_b, ext_irq_a, ext_irq_c, ext_reset_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel & penable & pready;
  wire wr  = acc & pwrite & pstrb[0];
  pull_off_a: assert property ((port_pullup_on[3:1] & port_pin_oe[3:1]) == 3'h0)
    else $error("pullup while driving");
  irq_b_gate_a: assert property (ext_irq_b |-> !port_pin_oe[3])
    else $error("irq b from output");
  irq_ac_gate_a: assert property (!((ext_irq_a & port_pin_oe[2]) | (ext_irq_c & port_pin_oe[1])))
    else $error("irq a or c from output");
  // Sync depth is two flops plus the output flop, so a pin shows three edges later
  irq_follow_a: assert property ($past(presetn, 3) && !port_pin_oe[3] && $past(port_pin_oe[3], 3) == 1'b0
    |-> ext_irq_b == $past(port_pin_in[3], 3)) else $error("irq b level");
  rst_mask_a: assert property (!ext_reset_n |-> !port_pin_oe[0])
    else $error("reset pin driven");
  latch_out_a: assert property (wr && paddr == (`GPP_IDX_LATCH << 2)
    |-> ##2 port_pin_out == $past(pwdata[3:0], 2)) else $error("latch to pin");
  dir_oe_a: assert property (wr && paddr == (`GPP_IDX_DIR << 2)
    |-> ##2 port_pin_oe[3:1] == $past(pwdata[3:1], 2)) else $error("direction to enable");
  read_zero_a: assert property (acc && !pwrite && paddr == (`GPP_IDX_PIN_IN << 2)
    |-> (prdata[3:1] & port_pin_oe[3:1]) == 3'h0) else $error("output bit read");
  cover property (ext_irq_b);
  cover property (acc && pslverr);
  cover property (!ext_reset_n);
endmodule
bind gpp_port gpp_port_properties chk (.*);
`default_nettype wire

/* sim/gpp_port_tb_top.sv */
// Self-checking testbench for the four-bit port
`timescale 1ns/10ps
`default_nettype none
`include "gpp_defs.vh"
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin fail_count++; \
  $display("Error %s exp %h got %h", n, e, a); end end
module gpp_port_tb_top;
  localparam [15:0] a_lat = `GPP_IDX_LATCH << 2, a_pin = `GPP_IDX_PIN_IN << 2;
  localparam [15:0] a_dir = `GPP_IDX_DIR << 2, a_pu = `GPP_IDX_PULLUP << 2;
  localparam [15:0] a_fn = `GPP_IDX_FUNC << 2;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  pstrb, port_pin_in, port_pin_out, port_pin_oe, port_pullup_on, en, val;
  logic        ext_irq_b, ext_irq_a, ext_irq_c, ext_reset_n;
  logic [32:0] q[$], exp_v;
  int          fail_count, checks;
  gpp_port uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .port_pin_in(port_pin_in), .port_pin_out(port_pin_out),
    .port_pin_oe(port_pin_oe), .port_pullup_on(port_pullup_on), .ext_irq_b(ext_irq_b),
    .ext_irq_a(ext_irq_a), .ext_irq_c(ext_irq_c), .ext_reset_n(ext_reset_n));
  gpp_pins_model brd (.pclk(pclk), .oe(port_pin_oe), .out(port_pin_out),
    .pu(port_pullup_on), .en(en), .val(val), .pin(port_pin_in));
  always #10 pclk = ~pclk;
  always @(posedge pclk) if (pready === 1'b1) begin
    exp_v = q.pop_front();
    `CHK("apb", exp_v, {pslverr, prdata})
  end
  task test_done;
    if (fail_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task apb(input [15:0] a, input w, input [3:0] d, input [32:0] e);
    int i;
    q.push_back(e);
    psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= {28'h0, d};
    @(posedge pclk) penable <= 1'b1;
    i = 0;
    do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin fail_count++; test_done; end
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    pstrb = 4'hf; en = 0; val = 0; fail_count = 0; checks = 0;
    r = $urandom(32'h0de0);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(a_lat, 0, 0, 0);
    apb(a_dir, 0, 0, 0);
    apb(a_pu, 0, 0, 0);
    apb(a_fn, 0, 0, 33'h1);
    r = $urandom;
    apb(a_dir, 1, 4'hf, 0);
    apb(a_lat, 1, r[3:0], 0);
    apb(a_lat, 0, 0, {29'h0, r[3:0]});
    pstrb <= 4'he;
    apb(a_lat, 1, ~r[3:0], 0);
    pstrb <= 4'hf;
    apb(a_lat, 0, 0, {29'h0, r[3:0]});
    apb(a_pin, 0, 0, 0);
    `CHK("pin_out", r[3:0], port_pin_out)
    `CHK("pin_oe", 4'he, port_pin_oe)
    apb(a_dir, 1, 0, 0);
    val <= r[7:4];
    en <= 4'hf;
    repeat (4) @(posedge pclk);
    apb(a_pin, 0, 0, {29'h0, r[7:4]});
    `CHK("irq", r[7:5], {ext_irq_b, ext_irq_a, ext_irq_c})
    `CHK("reset_pin", r[4], ext_reset_n)
    en <= 4'h0;
    apb(a_pu, 1, 4'hf, 0);
    repeat (4) @(posedge pclk);
    apb(a_pin, 0, 0, {29'h0, 4'hf});
    `CHK("pullup", 4'hf, port_pullup_on)
    apb(a_dir, 1, 4'h5, 0);
    @(posedge pclk);
    `CHK("pullup", 4'ha, port_pullup_on)
    apb(16'h0008, 0, 0, {1'b1, 32'h0});
    apb(a_pin, 1, 4'hf, {1'b1, 32'h0});
    apb(a_fn, 1, 0, 0);
    @(posedge pclk);
    `CHK("pin_oe", 4'h5, port_pin_oe)
    test_done;
  end
endmodule
`default_nettype wire

/* src/gpp_port.v */
// Four-bit I/O port with pull-ups, secondary inputs and an APB register slave
// Registers sit at word indices; the byte address is four times the index.
// The pin-input view is read only; a write to it is refused with pslverr.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "gpp_defs.vh"

module gpp_port (
  // Clock and reset
  input  wire                    pclk,
  input  wire                    presetn,

  // APB slave
  input  wire                    psel,
  input  wire                    penable,
  input  wire                    pwrite,
  input  wire [`GPP_AW-1:0]      paddr,
  input  wire [31:0]             pwdata,
  input  wire [3:0]              pstrb,
  output reg                     pready,
  output reg  [31:0]             prdata,
  output reg                     pslverr,

  // Port pins
  input  wire [`GPP_NBITS-1:0]   port_pin_in,
  output reg  [`GPP_NBITS-1:0]   port_pin_out,
  output reg  [`GPP_NBITS-1:0]   port_pin_oe,
  output reg  [`GPP_NBITS-1:0]   port_pullup_on,

  // Secondary inputs toward the rest of the chip
  output reg                     ext_irq_b,
  output reg                     ext_irq_a,
  output reg                     ext_irq_c,
  output reg                     ext_reset_n
);

  // Software-visible state
  reg [`GPP_NBITS-1:0] port_one_output_latch;
  reg [`GPP_NBITS-1:0] port_one_direction;
  reg [`GPP_NBITS-1:0] port_one_pullup_enable;
  reg                  reset_pin_mode;

  // Pin synchroniser
  reg [`GPP_NBITS-1:0] pin_meta;
  reg [`GPP_NBITS-1:0] pin_sync;

  // Register selects
  localparam SEL_NONE   = 5'b00000;
  localparam SEL_LATCH  = 5'b00001;
  localparam SEL_PIN_IN = 5'b00010;
  localparam SEL_DIR    = 5'b00100;
  localparam SEL_PULLUP = 5'b01000;
  localparam SEL_FUNC   = 5'b10000;

  // Decoded once, used for both read and write
  function [4:0] reg_select;
    input [`GPP_AW-1:0] addr;
    begin
      if (addr[1:0] != 2'b00) begin
        reg_select = SEL_NONE;
      end else begin
        case ({2'b00, addr[`GPP_AW-1:2]})
          `GPP_IDX_LATCH: begin
            reg_select = SEL_LATCH;
          end
          `GPP_IDX_PIN_IN: begin
            reg_select = SEL_PIN_IN;
          end
          `GPP_IDX_DIR: begin
            reg_select = SEL_DIR;
          end
          `GPP_IDX_PULLUP: begin
            reg_select = SEL_PULLUP;
          end
          `GPP_IDX_FUNC: begin
            reg_select = SEL_FUNC;
          end
          default: begin
            reg_select = SEL_NONE;
          end
        endcase
      end
    end
  endfunction

  wire [4:0]            sel      = reg_select(paddr);
  wire                  access   = psel & penable;
  // One wait state keeps read data and pready registered
  // Only byte lane 0 carries register bits, so pstrb[0] alone gates a write
  wire                  do_write = access & pready & pwrite & pstrb[0];
  wire [`GPP_NBITS-1:0] in_mode  = ~port_one_direction;

  // Bit 0 is never driven as an output while it serves as the reset input
  wire [`GPP_NBITS-1:0] port_mask = {{(`GPP_NBITS-1){1'b1}}, ~reset_pin_mode};

  // Pin-input view: live level for inputs, zero for outputs
  wire [`GPP_NBITS-1:0] pin_view = pin_sync & in_mode;

  // Refused transfers: unmapped or misaligned address, or a write to the pin view
  wire addr_unmapped = (sel == SEL_NONE);
  wire write_to_ro   = pwrite & (sel == SEL_PIN_IN);

  reg [31:0] next_prdata;
  reg        next_pslverr;

  // Unused upper bits read as zero
  always @* begin
    next_prdata  = 32'h0000_0000;
    next_pslverr = addr_unmapped | write_to_ro;
    case (sel)
      SEL_LATCH: begin
        next_prdata[`GPP_NBITS-1:0] = port_one_output_latch;
      end
      SEL_PIN_IN: begin
        next_prdata[`GPP_NBITS-1:0] = pin_view;
      end
      SEL_DIR: begin
        next_prdata[`GPP_NBITS-1:0] = port_one_direction;
      end
      SEL_PULLUP: begin
        next_prdata[`GPP_NBITS-1:0] = port_one_pullup_enable;
      end
      SEL_FUNC: begin
        next_prdata[`GPP_FUNC_RSTPIN] = reset_pin_mode;
      end
      default: begin
        next_prdata = 32'h0000_0000;
      end
    endcase
  end

  // Bus answer sequencer: idle until an access, then one answer cycle
  localparam ST_IDLE   = 2'b01;
  localparam ST_ANSWER = 2'b10;

  reg [1:0] state;
  reg [1:0] next_state;

  always @* begin
    case (state)
      ST_IDLE: begin
        next_state = access ? ST_ANSWER : ST_IDLE;
      end
      ST_ANSWER: begin
        // The master drops penable after the answer, so one cycle is enough
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  wire answer_now = (next_state == ST_ANSWER);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // APB handshake: pready rises in the second access cycle and stands one cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= answer_now;
      if (answer_now) begin
        prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
        pslverr <= next_pslverr;
      end else begin
        prdata  <= 32'h0000_0000;
        pslverr <= 1'b0;
      end
    end
  end

  // One write strobe per writable register, all from the same accepted transfer
  wire wr_latch  = do_write & (sel == SEL_LATCH);
  wire wr_dir    = do_write & (sel == SEL_DIR);
  wire wr_pullup = do_write & (sel == SEL_PULLUP);
  wire wr_func   = do_write & (sel == SEL_FUNC);

  // Register writes take effect at the edge where pready is sampled high
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_one_output_latch <= `GPP_RST_LATCH;
    end else if (wr_latch) begin
      port_one_output_latch <= pwdata[`GPP_NBITS-1:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_one_direction <= `GPP_RST_DIR;
    end else if (wr_dir) begin
      port_one_direction <= pwdata[`GPP_NBITS-1:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_one_pullup_enable <= `GPP_RST_PULLUP;
    end else if (wr_pullup) begin
      port_one_pullup_enable <= pwdata[`GPP_NBITS-1:0];
    end
  end

  // Writing 0 frees bit 0 as a port pin; writing 1 restores the reset input
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_pin_mode <= `GPP_RST_FUNC;
    end else if (wr_func) begin
      reset_pin_mode <= pwdata[`GPP_FUNC_RSTPIN];
    end
  end

  // Two flip-flops before any logic looks at the pins
  // The first stage may go metastable, so only the second is ever read
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= {`GPP_NBITS{1'b0}};
      pin_sync <= {`GPP_NBITS{1'b0}};
    end else begin
      pin_meta <= port_pin_in;
      pin_sync <= pin_meta;
    end
  end

  // Per-bit drive enable and pull-up connection
  wire [`GPP_NBITS-1:0] next_pin_oe;
  wire [`GPP_NBITS-1:0] next_pullup_on;

  genvar gi;
  generate
    for (gi = 0; gi < `GPP_NBITS; gi = gi + 1) begin : g_bit
      assign next_pin_oe[gi]    = port_one_direction[gi] & port_mask[gi];
      // A pull-up fighting a driven pin would only waste current
      assign next_pullup_on[gi] = port_one_pullup_enable[gi] & in_mode[gi];
    end
  endgenerate

  // Pin drive and pull-ups, registered so outputs come from flip-flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_pin_out   <= {`GPP_NBITS{1'b0}};
      port_pin_oe    <= {`GPP_NBITS{1'b0}};
      port_pullup_on <= {`GPP_NBITS{1'b0}};
    end else begin
      port_pin_out   <= port_one_output_latch;
      port_pin_oe    <= next_pin_oe;
      port_pullup_on <= next_pullup_on;
    end
  end

  // Secondary-input levels; an output bit feeds nothing to the interrupt side
  reg next_irq_b;
  reg next_irq_a;
  reg next_irq_c;
  reg next_reset_n;

  always @* begin
    next_irq_b   = pin_view[`GPP_BIT_IRQ_B];
    next_irq_a   = pin_view[`GPP_BIT_IRQ_A];
    next_irq_c   = pin_view[`GPP_BIT_IRQ_C];
    // Synchronised bit-0 level, held high once bit 0 is freed; the reset controller decides what a low level means
    next_reset_n = ~reset_pin_mode | pin_sync[`GPP_BIT_RESET];
  end

  // Interrupt levels idle low after reset, the reset request idles high
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_irq_b   <= 1'b0;
      ext_irq_a   <= 1'b0;
      ext_irq_c   <= 1'b0;
      ext_reset_n <= 1'b1;
    end else begin
      ext_irq_b   <= next_irq_b;
      ext_irq_a   <= next_irq_a;
      ext_irq_c   <= next_irq_c;
      ext_reset_n <= next_reset_n;
    end
  end

endmodule

`default_nettype wire
